// ### core/bank_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module bank_tracker import ddr2_host_pkg::*; #(
    parameter logic [1:0] BANK_ID = 2'h0
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        cs_n_nxt,
    input  wire logic        ras_n_nxt,
    input  wire logic        cas_n_nxt,
    input  wire logic        we_n_nxt,
    input  wire logic [1:0]  ba_nxt,
    input  wire logic        a10_nxt,
    output logic             rd_ok,
    output logic             wr_ok,
    output logic             act_ok,
    output logic             pre_ok,
    output logic             is_idle,
    output logic             row_open
);

    bank_state_t state_r;
    bank_state_t state_nxt;
    cnt_t        cnt_r;
    cnt_t        cnt_nxt;
    cmd_t        cmd;
    logic        hit;

    // ------------------------------------------------------------
    // Next state from the command going onto the pins
    // ------------------------------------------------------------
    always_comb begin
        cmd       = decode_cmd(cs_n_nxt, ras_n_nxt, cas_n_nxt, we_n_nxt);
        hit       = (ba_nxt == BANK_ID);
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
        if (hit && cmd == CMD_READ) begin
            state_nxt = a10_nxt ? BK_READ_AP : BK_READ;
            cnt_nxt   = BURST_LD;
        end else if (hit && cmd == CMD_WRITE) begin
            state_nxt = a10_nxt ? BK_WRITE_AP : BK_WRITE;
            cnt_nxt   = WDATA_LD;
        end else begin
            unique case (state_r)
                BK_IDLE: begin
                    if (hit && cmd == CMD_ACT) begin
                        state_nxt = BK_ACTIVATING;
                        cnt_nxt   = TRCD_LD;
                    end
                end
                BK_ACTIVATING: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_ACTIVE;
                    end
                end
                BK_ACTIVE: begin
                    if (cmd == CMD_PRE && (hit || a10_nxt)) begin
                        state_nxt = BK_PRECHARGING;
                        cnt_nxt   = TRP_LD;
                    end
                end
                BK_READ: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_ACTIVE;
                    end
                end
                BK_WRITE: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_WREC;
                        cnt_nxt   = TWR_LD;
                    end
                end
                BK_WRITE_AP: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_WREC_AP;
                        cnt_nxt   = TWR_LD;
                    end
                end
                BK_WREC: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_ACTIVE;
                    end
                end
                BK_READ_AP, BK_WREC_AP: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_PRECHARGING;
                        cnt_nxt   = TRP_LD;
                    end
                end
                BK_PRECHARGING: begin
                    if (cnt_r == '0) begin
                        state_nxt = BK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= BK_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Legality for this bank
    // ------------------------------------------------------------
    // Column access while activating only if additive latency covers it
    assign rd_ok = (state_r == BK_ACTIVE)
                || (state_r == BK_READ && cnt_r == '0)
                || (state_r == BK_ACTIVATING && cnt_r < AL_LIM)
                || (state_r == BK_WREC && cnt_r <= WTR_LIM);
    assign wr_ok = (state_r == BK_ACTIVE)
                || (state_r == BK_WRITE && cnt_r == '0)
                || (state_r == BK_ACTIVATING && cnt_r < AL_LIM)
                || (state_r == BK_WREC);
    assign act_ok   = (state_r == BK_IDLE);
    // Burst, recovery and activating states refuse any precharge
    assign pre_ok   = (state_r == BK_IDLE) || (state_r == BK_ACTIVE)
                   || (state_r == BK_PRECHARGING);
    assign is_idle  = (state_r == BK_IDLE);
    assign row_open = (state_r == BK_ACTIVE);

endmodule // bank_tracker
`default_nettype wire

// ### core/ddr2_cmd_host.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_cmd_host import ddr2_host_pkg::*; (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              req_valid,
    input  wire cmd_t              req_cmd,
    input  wire logic [BA_W-1:0]   req_bank,
    input  wire logic [ADDR_W-1:0] req_addr,
    output logic                   req_ready,
    input  wire logic              ext_temp_en,
    output logic                   ref_pending,
    output logic [NUM_BANKS-1:0]   open_rows,
    output logic                   dram_cke,
    output logic                   dram_cs_n,
    output logic                   dram_ras_n,
    output logic                   dram_cas_n,
    output logic                   dram_we_n,
    output logic [BA_W-1:0]        dram_ba,
    output logic [ADDR_W-1:0]      dram_addr
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    host_state_t          host_r;
    host_state_t          host_nxt;
    cnt_t                 gcnt_r;
    cmd_t                 issue_cmd;
    logic [BA_W-1:0]      issue_ba;
    logic [ADDR_W-1:0]    issue_addr;
    logic [3:0]           pins_nxt;
    logic                 req_legal;
    logic                 ref_due;
    logic                 ref_issue;
    logic                 cke_r;
    logic [NUM_BANKS-1:0] bank_rd_ok;
    logic [NUM_BANKS-1:0] bank_wr_ok;
    logic [NUM_BANKS-1:0] bank_act_ok;
    logic [NUM_BANKS-1:0] bank_pre_ok;
    logic [NUM_BANKS-1:0] bank_idle;
    logic [NUM_BANKS-1:0] bank_open;

    // ------------------------------------------------------------
    // Legality of the user request
    // ------------------------------------------------------------
    function automatic logic legal_for(input cmd_t cmd,
                                       input logic [BA_W-1:0] bank,
                                       input logic a10);
        unique case (cmd)
            CMD_READ:  return bank_rd_ok[bank];
            CMD_WRITE: return bank_wr_ok[bank];
            CMD_ACT:   return bank_act_ok[bank];
            // Single-bank precharge looks at its own bank only
            CMD_PRE:   return a10 ? (&bank_pre_ok)
                                  : bank_pre_ok[bank];
            CMD_REF,
            CMD_MRS:   return &bank_idle;
            default:   return 1'b1;
        endcase
    endfunction

    always_comb req_legal = legal_for(req_cmd, req_bank,
                                      req_addr[A10_POS]);

    // ------------------------------------------------------------
    // Command selection
    // ------------------------------------------------------------
    always_comb begin
        host_nxt   = host_r;
        issue_cmd  = CMD_NOP;
        issue_ba   = '0;
        issue_addr = '0;
        req_ready  = 1'b0;
        unique case (host_r)
            H_RUN: begin
                if (ref_due) begin
                    host_nxt = H_DRAIN;
                end else if (req_valid && req_legal) begin
                    req_ready  = 1'b1;
                    issue_cmd  = req_cmd;
                    issue_ba   = req_bank;
                    issue_addr = req_addr;
                    if (req_cmd == CMD_MRS && req_bank == EMRS2_BANK) begin
                        issue_addr[A7_POS] = ext_temp_en;
                    end
                    if (req_cmd == CMD_REF) begin
                        host_nxt = H_REF_WAIT;
                    end else if (req_cmd == CMD_MRS) begin
                        host_nxt = H_MRS_WAIT;
                    end
                end
            end
            H_DRAIN: begin
                if (&bank_idle) begin
                    issue_cmd = CMD_REF;
                    host_nxt  = H_REF_WAIT;
                end else if ((&bank_pre_ok) && (|bank_open)) begin
                    issue_cmd           = CMD_PRE;
                    issue_addr[A10_POS] = 1'b1;
                end
            end
            H_REF_WAIT: begin
                if (gcnt_r == '0) begin
                    host_nxt = H_RUN;
                end
            end
            H_MRS_WAIT: begin
                if (gcnt_r == '0) begin
                    host_nxt = H_RUN;
                end
            end
        endcase
    end

    assign pins_nxt  = encode_cmd(issue_cmd);
    assign ref_issue = (issue_cmd == CMD_REF);

    // ------------------------------------------------------------
    // Host state and device-wide busy counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            host_r <= H_RUN;
        end else begin
            host_r <= host_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gcnt_r <= '0;
        end else if (issue_cmd == CMD_REF) begin
            gcnt_r <= TRFC_LD;
        end else if (issue_cmd == CMD_MRS) begin
            gcnt_r <= TMRD_LD;
        end else if (gcnt_r != '0) begin
            gcnt_r <= gcnt_r - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registered device pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cke_r <= 1'b0;
        end else begin
            cke_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dram_cs_n  <= 1'b1;
            dram_ras_n <= 1'b1;
            dram_cas_n <= 1'b1;
            dram_we_n  <= 1'b1;
            dram_ba    <= '0;
            dram_addr  <= '0;
        end else begin
            dram_cs_n  <= pins_nxt[3];
            dram_ras_n <= pins_nxt[2];
            dram_cas_n <= pins_nxt[1];
            dram_we_n  <= pins_nxt[0];
            dram_ba    <= issue_ba;
            dram_addr  <= issue_addr;
        end
    end

    assign dram_cke  = cke_r;
    assign open_rows = bank_open;

    // ------------------------------------------------------------
    // Per-bank trackers, fed with the command as it goes out
    // ------------------------------------------------------------
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        bank_tracker #(
            .BANK_ID (2'(b))
        ) u_bank (
            .core_clk  (core_clk),
            .sys_rst   (sys_rst),
            .cs_n_nxt  (pins_nxt[3]),
            .ras_n_nxt (pins_nxt[2]),
            .cas_n_nxt (pins_nxt[1]),
            .we_n_nxt  (pins_nxt[0]),
            .ba_nxt    (issue_ba),
            .a10_nxt   (issue_addr[A10_POS]),
            .rd_ok     (bank_rd_ok[b]),
            .wr_ok     (bank_wr_ok[b]),
            .act_ok    (bank_act_ok[b]),
            .pre_ok    (bank_pre_ok[b]),
            .is_idle   (bank_idle[b]),
            .row_open  (bank_open[b])
        );
    end

    // ------------------------------------------------------------
    // Refresh interval
    // ------------------------------------------------------------
    refresh_timer u_refresh (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .ext_temp_en (ext_temp_en),
        .ref_issued  (ref_issue),
        .ref_due     (ref_due)
    );

    assign ref_pending = ref_due;

endmodule // ddr2_cmd_host
`default_nettype wire

// ### core/ddr2_host_pkg.sv
package ddr2_host_pkg;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP   = 3'h0,
        CMD_READ  = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_ACT   = 3'h3,
        CMD_PRE   = 3'h4,
        CMD_REF   = 3'h5,
        CMD_MRS   = 3'h6,
        CMD_DESEL = 3'h7
    } cmd_t;

    typedef enum logic [9:0] {
        BK_IDLE        = 10'h001,
        BK_ACTIVATING  = 10'h002,
        BK_ACTIVE      = 10'h004,
        BK_READ        = 10'h008,
        BK_READ_AP     = 10'h010,
        BK_WRITE       = 10'h020,
        BK_WRITE_AP    = 10'h040,
        BK_WREC        = 10'h080,
        BK_WREC_AP     = 10'h100,
        BK_PRECHARGING = 10'h200
    } bank_state_t;

    typedef enum logic [3:0] {
        H_RUN      = 4'h1,
        H_DRAIN    = 4'h2,
        H_REF_WAIT = 4'h4,
        H_MRS_WAIT = 4'h8
    } host_state_t;

    // ------------------------------------------------------------
    // Widths and fields
    // ------------------------------------------------------------
    localparam int         NUM_BANKS  = 4;
    localparam int         BA_W       = 2;
    localparam int         ADDR_W     = 13;
    localparam int         A10_POS    = 10;
    localparam int         A7_POS     = 7;
    localparam logic [1:0] EMRS2_BANK = 2'h2;
    localparam int         CNT_W      = 8;
    localparam int         REF_W      = 10;
    typedef logic [CNT_W-1:0] cnt_t;
    typedef logic [REF_W-1:0] ref_cnt_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 20;
    localparam int T_RP_NS        = 15;
    localparam int T_RCD_NS       = 15;
    localparam int T_WR_NS        = 15;
    localparam int T_WTR_NS       = 10;
    localparam int T_RFC_NS       = 105;
    localparam int T_MRD_CK       = 2;
    localparam int T_REFI_NS      = 7800;
    localparam int T_REFI_EXT_NS  = 3900;
    localparam int AL_CYC         = 0;
    localparam int CL_CYC         = 3;
    localparam int BURST_CYC      = 2;

    function automatic int cyc_min(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int t_ns);
        int c;
        c = t_ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int TRP_CYC   = cyc_min(T_RP_NS);
    localparam int TRCD_CYC  = cyc_min(T_RCD_NS);
    localparam int TWR_CYC   = cyc_min(T_WR_NS);
    localparam int TWTR_CYC  = cyc_min(T_WTR_NS);
    localparam int TRFC_CYC  = cyc_min(T_RFC_NS);
    localparam int WDATA_CYC = AL_CYC + CL_CYC - 1 + BURST_CYC;

    localparam cnt_t TRP_LD   = cnt_t'(TRP_CYC - 1);
    localparam cnt_t TRCD_LD  = cnt_t'(TRCD_CYC - 1);
    localparam cnt_t TWR_LD   = cnt_t'(TWR_CYC - 1);
    localparam cnt_t TRFC_LD  = cnt_t'(TRFC_CYC - 1);
    localparam cnt_t TMRD_LD  = cnt_t'(T_MRD_CK - 1);
    localparam cnt_t BURST_LD = cnt_t'(BURST_CYC - 1);
    localparam cnt_t WDATA_LD = cnt_t'(WDATA_CYC - 1);
    localparam cnt_t AL_LIM   = cnt_t'(AL_CYC);
    localparam cnt_t WTR_LIM  = cnt_t'(TWR_CYC - TWTR_CYC);
    localparam ref_cnt_t REFI_LD     = ref_cnt_t'(cyc_max(T_REFI_NS) - 1);
    localparam ref_cnt_t REFI_EXT_LD = ref_cnt_t'(cyc_max(T_REFI_EXT_NS) - 1);

    // ------------------------------------------------------------
    // Pin coding of commands: {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        if (cs_n) begin
            return CMD_DESEL;
        end
        unique case ({ras_n, cas_n, we_n})
            3'h5:    return CMD_READ;
            3'h4:    return CMD_WRITE;
            3'h3:    return CMD_ACT;
            3'h2:    return CMD_PRE;
            3'h1:    return CMD_REF;
            3'h0:    return CMD_MRS;
            default: return CMD_NOP;
        endcase
    endfunction

    function automatic logic [3:0] encode_cmd(input cmd_t cmd);
        unique case (cmd)
            CMD_READ:  return 4'h5;
            CMD_WRITE: return 4'h4;
            CMD_ACT:   return 4'h3;
            CMD_PRE:   return 4'h2;
            CMD_REF:   return 4'h1;
            CMD_MRS:   return 4'h0;
            CMD_NOP:   return 4'h7;
            default:   return 4'h8;
        endcase
    endfunction

endpackage

// ### core/refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module refresh_timer import ddr2_host_pkg::*; (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic ext_temp_en,
    input  wire logic ref_issued,
    output logic      ref_due
);

    ref_cnt_t cnt_r;
    logic     due_r;

    // Half interval in the extended temperature range
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r <= REFI_LD;
        end else if (cnt_r == '0) begin
            cnt_r <= ext_temp_en ? REFI_EXT_LD : REFI_LD;
        end else begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // A new tick wins over the clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            due_r <= 1'b0;
        end else begin
            due_r <= (cnt_r == '0) || (due_r && !ref_issued);
        end
    end

    assign ref_due = due_r;

endmodule // refresh_timer
`default_nettype wire

// ### test/ddr2_cmd_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_cmd_host_assertions import ddr2_host_pkg::*; (
    input wire logic                 core_clk,
    input wire logic                 sys_rst,
    input wire logic                 req_valid,
    input wire cmd_t                 req_cmd,
    input wire logic [BA_W-1:0]      req_bank,
    input wire logic [ADDR_W-1:0]    req_addr,
    input wire logic                 req_ready,
    input wire logic                 ext_temp_en,
    input wire logic                 ref_pending,
    input wire logic [NUM_BANKS-1:0] open_rows,
    input wire logic                 dram_cke,
    input wire logic                 dram_cs_n,
    input wire logic                 dram_ras_n,
    input wire logic                 dram_cas_n,
    input wire logic                 dram_we_n,
    input wire logic [BA_W-1:0]      dram_ba,
    input wire logic [ADDR_W-1:0]    dram_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ------
    // Pin decode
    // ------
    wire logic take = req_valid && req_ready;
    wire logic nop  = dram_cs_n || (dram_ras_n && dram_cas_n && dram_we_n);
    wire logic glob = !dram_cs_n && !dram_ras_n && !dram_cas_n;
    wire logic is_ref = glob && dram_we_n;
    wire logic is_mrs = glob && !dram_we_n;
    wire logic is_act = !dram_cs_n && !dram_ras_n && dram_cas_n && dram_we_n;
    wire logic is_col = !dram_cs_n && dram_ras_n && !dram_cas_n;

    sequence s_quiet5; nop [*5]; endsequence
    sequence s_act_out;
        is_act ##0 (dram_ba == $past(req_bank) && dram_addr == $past(req_addr));
    endsequence

    property p_act_pins; take && req_cmd == CMD_ACT |=> s_act_out; endproperty
    property p_ref_block; is_ref |=> s_quiet5; endproperty
    property p_mrs_block; is_mrs |=> nop; endproperty
    property p_ref_idle; is_ref |-> open_rows == 4'h0; endproperty
    property p_quiet; !take && !ref_pending |=> nop; endproperty
    property p_emrs2;
        take && req_cmd == CMD_MRS && req_bank == EMRS2_BANK && ext_temp_en
            |=> dram_addr[A7_POS];
    endproperty
    property p_act_twice;
        is_act |=> !(is_act && dram_ba == $past(dram_ba));
    endproperty
    property p_ap_bank;
        is_col && dram_addr[A10_POS]
            |=> nop || (dram_ba != $past(dram_ba) && !glob);
    endproperty

    a_act_pins: assert property (p_act_pins)
        else $error("activate not on pins");
    a_ref_block: assert property (p_ref_block)
        else $error("command inside refresh time");
    a_mrs_block: assert property (p_mrs_block)
        else $error("command inside mode set time");
    a_ref_idle: assert property (p_ref_idle)
        else $error("refresh with open row");
    a_quiet: assert property (p_quiet)
        else $error("command without request");
    a_emrs2: assert property (p_emrs2)
        else $error("hot self-refresh bit missing");
    a_act_twice: assert property (p_act_twice)
        else $error("second activate to bank");
    a_ap_bank: assert property (p_ap_bank)
        else $error("command to auto precharge bank");
endmodule // ddr2_cmd_host_assertions
`default_nettype wire

// ### test/ddr2_cmd_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_cmd_host_bench import ddr2_host_pkg::*;;
    logic              core_clk, sys_rst, req_valid, req_ready, ext_temp_en;
    logic              ref_pending, dram_cke, cs_n, ras_n, cas_n, we_n, hot_sr;
    cmd_t              req_cmd;
    logic [BA_W-1:0]   req_bank, dram_ba;
    logic [ADDR_W-1:0] req_addr, dram_addr;
    logic [3:0]        open_rows;
    int                n_fail, n_compared, n_bad;

    ddr2_cmd_host dut (.core_clk, .sys_rst, .req_valid, .req_cmd, .req_bank,
        .req_addr, .req_ready, .ext_temp_en, .ref_pending, .open_rows,
        .dram_cke, .dram_cs_n(cs_n), .dram_ras_n(ras_n), .dram_cas_n(cas_n),
        .dram_we_n(we_n), .dram_ba, .dram_addr);
    ddr2_dev_model mem (.core_clk, .cke(dram_cke), .cs_n, .ras_n, .cas_n,
        .we_n, .ba(dram_ba), .addr(dram_addr), .n_bad, .hot_sr);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ------
    // Shared tasks
    // ------
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic put(input logic v, input cmd_t c, input logic [1:0] b,
                       input logic [12:0] a);
        req_valid = v;
        req_cmd   = c;
        req_bank  = b;
        req_addr  = a;
    endtask

    task automatic idle();
        put(1'b0, CMD_NOP, 2'h0, 13'h0000);
        @(posedge core_clk);
        #2;
    endtask

    // Request left up; the next call or put replaces it
    task automatic issue(input cmd_t c, input logic [1:0] b,
                         input logic [12:0] a, input logic [3:0] pins);
        int k;
        put(1'b1, c, b, a);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (req_ready !== 1'b1 && k < 60);
        @(posedge core_clk);
        #2;
        check(k < 60 && {cs_n, ras_n, cas_n, we_n} === pins
              && dram_ba === b, "command not on pins");
    endtask

    task automatic refused(input cmd_t c, input logic [1:0] b, input int n);
        put(1'b1, c, b, 13'h0000);
        repeat (n) begin
            @(negedge core_clk);
            check(req_ready === 1'b0, "illegal request taken");
        end
        @(posedge core_clk);
        #2;
    endtask

    task automatic close_out();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_open_read();
        issue(CMD_ACT, 2'h0, 13'h1abc, 4'h3);
        issue(CMD_READ, 2'h0, 13'h0010, 4'h5);
        issue(CMD_READ, 2'h0, 13'h0410, 4'h5);
        refused(CMD_ACT, 2'h0, 2);
        issue(CMD_ACT, 2'h1, 13'h0055, 4'h3);
        idle();
        $display("t_open_read done");
    endtask

    task automatic t_write_ap();
        issue(CMD_ACT, 2'h2, 13'h0123, 4'h3);
        issue(CMD_WRITE, 2'h2, 13'h0008, 4'h4);
        issue(CMD_READ, 2'h2, 13'h0008, 4'h5);
        issue(CMD_WRITE, 2'h2, 13'h0408, 4'h4);
        refused(CMD_READ, 2'h2, 2);
        refused(CMD_READ, 2'h3, 2);
        idle();
        $display("t_write_ap done");
    endtask

    task automatic t_ref_mrs();
        issue(CMD_PRE, 2'h0, 13'h0400, 4'h2);
        check(dram_addr[A10_POS] === 1'b1, "all-bank bit lost");
        issue(CMD_REF, 2'h0, 13'h0000, 4'h1);
        refused(CMD_ACT, 2'h0, 2);
        ext_temp_en = 1'b1;
        issue(CMD_MRS, EMRS2_BANK, 13'h0000, 4'h0);
        check(dram_addr[A7_POS] === 1'b1, "hot bit not set");
        refused(CMD_ACT, 2'h1, 1);
        idle();
        $display("t_ref_mrs done");
    endtask

    // Next interval is halved
    task automatic t_auto_ref();
        int k;
        k = 0;
        while (ref_pending !== 1'b1 && k < 400) begin
            @(negedge core_clk);
            k++;
        end
        k = 0;
        while ({cs_n, ras_n, cas_n, we_n} !== 4'h1 && k < 20) begin
            @(negedge core_clk);
            k++;
        end
        check(k < 20, "refresh not issued");
        while (ref_pending !== 1'b1 && k < 400) begin
            @(negedge core_clk);
            k++;
        end
        check(k == T_REFI_EXT_NS / CLK_PERIOD_NS,
              "refresh interval not halved");
        $display("t_auto_ref done");
    endtask

    initial begin
        n_fail      = 0;
        n_compared  = 0;
        sys_rst     = 1'b1;
        ext_temp_en = 1'b0;
        put(1'b0, CMD_NOP, 2'h0, 13'h0000);
        repeat (5) @(posedge core_clk);
        #2 sys_rst = 1'b0;
        t_open_read();
        t_write_ap();
        t_ref_mrs();
        t_auto_ref();
        check(n_bad === 0, "device saw illegal command");
        check(hot_sr === 1'b1, "device hot mode off");
        close_out();
    end

    // Tests need about 600 cycles; allow three times that
    initial begin
        #40000;
        n_fail++;
        close_out();
    end
endmodule // ddr2_cmd_host_bench

bind ddr2_cmd_host ddr2_cmd_host_assertions chk (.core_clk, .sys_rst,
    .req_valid, .req_cmd, .req_bank, .req_addr, .req_ready, .ext_temp_en,
    .ref_pending, .open_rows, .dram_cke, .dram_cs_n, .dram_ras_n,
    .dram_cas_n, .dram_we_n, .dram_ba, .dram_addr);
`default_nettype wire

// ### test/ddr2_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_dev_model import ddr2_host_pkg::*; (
    input  wire logic              core_clk,
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic [ADDR_W-1:0] addr,
    output int                     n_bad,
    output logic                   hot_sr
);
    logic [3:0] open_r;
    logic [2:0] s;
    int         busy [4];
    int         gbusy;

    initial begin
        n_bad  = 0;
        hot_sr = 1'b0;
        open_r = 4'h0;
        gbusy  = 0;
        busy   = '{0, 0, 0, 0};
    end

    // Counters first, so a load lasts its full count
    always @(posedge core_clk) begin
        s = {ras_n, cas_n, we_n};
        if (gbusy > 0) gbusy--;
        foreach (busy[i]) if (busy[i] > 0) busy[i]--;
        if (cke && !cs_n && s != 3'h7) begin
            if (gbusy > 0) n_bad++;
            case (s)
                3'h3: begin
                    if (open_r[ba] || busy[ba] > 0) n_bad++;
                    open_r[ba] = 1'b1;
                end
                3'h5, 3'h4: begin
                    if (!open_r[ba] || busy[ba] > 0) n_bad++;
                    if (addr[A10_POS]) open_r[ba] = 1'b0;
                    if (addr[A10_POS]) busy[ba] = BURST_CYC;
                end
                3'h2: begin
                    if (busy[ba] > 0) n_bad++;
                    if (addr[A10_POS]) open_r = 4'h0;
                    else open_r[ba] = 1'b0;
                end
                3'h1: begin
                    if (open_r != 4'h0) n_bad++;
                    gbusy = TRFC_CYC;
                end
                3'h0: begin
                    if (open_r != 4'h0) n_bad++;
                    gbusy = T_MRD_CK;
                    if (ba == EMRS2_BANK) hot_sr = addr[A7_POS];
                end
                default: ;
            endcase
        end
    end
endmodule // ddr2_dev_model
`default_nettype wire
